// file: core/chb_cfg_pkg.sv
// Purpose: Constants for second-channel line length and test vertical size block
// Assumes: Avalon-MM register access, one 100 MHz clock
// Notes:   Summary of operation below
// Summary of operation
// [R1] Second channel line length is 12 bits: low register gives 7:0, high register 3:0 gives 11:8.
// [R2] With a single input configured the second channel line length is not used at all.
// [R3] In odd/even dual input the second length counts even pixels per line on input two.
// [R4] In left/right dual input the second length counts right-half pixels to output two.
// [R5] In two-stream mode the second length is the active pixels per line of stream two.
// [R6] With right trimming in left/right mode software loads the trimmed right pixel count.
// [R7] The first 12-bit vertical size sets the test pattern frame height on output one, and on output two outside two-stream mode.
// [R8] The second vertical size applies to output two only when channel mode is 10 and dual output is selected.
// [R9] Channel mode 10 with dual output selected means two independent single streams.
// [R10] Test line counter starts at zero, wraps after the set size, one vsync per frame.
package chb_cfg_pkg;
  localparam logic [7:0]  OFS_LEN2_LO    = 8'h22;
  localparam logic [7:0]  OFS_LEN2_HI    = 8'h23;
  localparam logic [7:0]  OFS_VS1_LO     = 8'h24;
  localparam logic [7:0]  OFS_VS1_HI     = 8'h25;
  localparam logic [7:0]  OFS_VS2_LO     = 8'h26;
  localparam logic [7:0]  OFS_VS2_HI     = 8'h27;
  localparam logic [7:0]  OFS_MODE       = 8'h28;
  localparam logic [7:0]  OFS_STATUS     = 8'h29;
  localparam int          HI_W           = 4;
  localparam logic [7:0]  REG_RST        = 8'h00;
  localparam logic [1:0]  MODE_RST       = 2'h0;
  localparam int          MODE_CH_LSB    = 0;
  localparam int          MODE_DUALIN    = 2;
  localparam int          MODE_DUALOUT   = 3;
  localparam int          MODE_ODDEVEN   = 4;
  localparam logic [1:0]  CHMODE_TWO     = 2'h2;
  typedef enum logic [1:0] {
    USE_NONE     = 2'h0,
    USE_ODD_EVEN = 2'h1,
    USE_TWO_STR  = 2'h3,
    USE_LEFT_RT  = 2'h2
  } len_use_e;
endpackage

// file: core/chb_line_length_and_test_vsize.sv
// Purpose: Second-channel line length, test pattern vertical sizes and line counters
// Assumes: Avalon-MM slave, word offsets are register indexes (byte address = 4 x index)
// Notes:   Test line advance comes in as a one-cycle enable
module chb_line_length_and_test_vsize
  import chb_cfg_pkg::*;
#(
  parameter int LEN_W = 12
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rstn_i,
  input  wire logic [9:0]       avs_address_i,
  input  wire logic             avs_read_i,
  input  wire logic             avs_write_i,
  input  wire logic [31:0]      avs_writedata_i,
  input  wire logic [3:0]       avs_byteenable_i,
  output logic [31:0]           avs_readdata_o,
  output logic                  avs_waitrequest_o,
  output logic [1:0]            avs_response_o,
  input  wire logic             line_en_i,
  output logic [LEN_W-1:0]      len2_o,
  output logic                  len2_valid_o,
  output logic [1:0]            len2_use_o,
  output logic [LEN_W-1:0]      vsize2_o,
  output logic [LEN_W-1:0]      line1_o,
  output logic [LEN_W-1:0]      line2_o,
  output logic                  vsync1_o,
  output logic                  vsync2_o
);

  logic [7:0]       regs_r   [0:6];
  logic [7:0]       regs_nxt [0:6];
  logic [31:0]      rdata_r,  rdata_nxt;
  logic [1:0]       resp_r,   resp_nxt;
  logic             ack_r,    ack_nxt;
  logic [LEN_W-1:0] cnt1_r,   cnt1_nxt;
  logic [LEN_W-1:0] cnt2_r,   cnt2_nxt;
  logic             vs1_r,    vs1_nxt;
  logic             vs2_r,    vs2_nxt;
  logic [LEN_W-1:0] len2_r,   len2_nxt;
  logic             lval_r,   lval_nxt;
  logic [1:0]       use_r,    use_nxt;
  logic [LEN_W-1:0] vs2sz_r,  vs2sz_nxt;
  logic [LEN_W-1:0] vsize1;
  logic             two_str;

  // Register index decode
  function automatic int reg_idx(input logic [7:0] a);
    if (a >= OFS_LEN2_LO && a <= OFS_MODE) begin
      return int'(a - OFS_LEN2_LO);
    end
    return -1;
  endfunction

  // Join low byte and 4-bit high part
  function automatic logic [LEN_W-1:0] join12(input logic [7:0] lo, input logic [7:0] hi);
    return LEN_W'({hi[HI_W-1:0], lo});
  endfunction

  logic [7:0] widx;
  logic       hit;
  logic       req;
  assign req  = (avs_read_i | avs_write_i) & ~ack_r;
  assign widx = avs_address_i[9:2];
  assign hit  = (avs_address_i[1:0] == 2'h0) &&
                ((reg_idx(widx) >= 0) || (widx == OFS_STATUS));

  // Bus access, one wait cycle
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      regs_nxt[i] = regs_r[i];
    end
    // Read data and response stand until the next access
    rdata_nxt = rdata_r;
    resp_nxt  = resp_r;
    ack_nxt   = req;
    if (req) begin
      resp_nxt = hit ? 2'h0 : 2'h2;
      if (avs_read_i) begin
        rdata_nxt = 32'h0000_0000;
      end
      if (avs_write_i && avs_byteenable_i[0] && reg_idx(widx) >= 0) begin
        regs_nxt[reg_idx(widx)] = avs_writedata_i[7:0];
      end
      if (avs_read_i && reg_idx(widx) >= 0) begin
        rdata_nxt = {24'h00_0000, regs_r[reg_idx(widx)]};
      end else if (avs_read_i && widx == OFS_STATUS) begin
        rdata_nxt = {30'h0000_0000, vs2_r, vs1_r};
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < 7; i++) begin
        regs_r[i] <= REG_RST;
      end
      rdata_r <= 32'h0000_0000;
      resp_r  <= 2'h0;
      ack_r   <= 1'b0;
    end else begin
      for (int i = 0; i < 7; i++) begin
        regs_r[i] <= regs_nxt[i];
      end
      rdata_r <= rdata_nxt;
      resp_r  <= resp_nxt;
      ack_r   <= ack_nxt;
    end
  end

  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_r;
  assign avs_readdata_o    = rdata_r;
  assign avs_response_o    = resp_r;

  // [R9] Two independent streams
  assign two_str = (regs_r[6][MODE_CH_LSB +: 2] == CHMODE_TWO) && regs_r[6][MODE_DUALOUT];
  // [R7] First vertical size
  assign vsize1  = join12(regs_r[2], regs_r[3]);

  // Mode-dependent use of second length
  always_comb begin
    // [R1] Join line length
    len2_nxt  = join12(regs_r[0], regs_r[1]);
    lval_nxt  = 1'b1;
    use_nxt   = USE_NONE;
    // [R8] Second size gated
    vs2sz_nxt = two_str ? join12(regs_r[4], regs_r[5]) : vsize1;
    if (!regs_r[6][MODE_DUALIN]) begin
      // [R2] Single input ignores
      len2_nxt = '0;
      lval_nxt = 1'b0;
    end else if (two_str) begin
      // [R5] Stream two length
      use_nxt = USE_TWO_STR;
    end else if (regs_r[6][MODE_ODDEVEN]) begin
      // [R3] Even pixel count
      use_nxt = USE_ODD_EVEN;
    end else begin
      // [R4] Right half count, [R6] trimmed by software
      use_nxt = USE_LEFT_RT;
    end
  end

  // [R10] Line counters and vsync
  always_comb begin
    cnt1_nxt = cnt1_r;
    cnt2_nxt = cnt2_r;
    vs1_nxt  = 1'b0;
    vs2_nxt  = 1'b0;
    if (line_en_i) begin
      if (cnt1_r + 1'b1 >= vsize1) begin
        cnt1_nxt = '0;
        vs1_nxt  = 1'b1;
      end else begin
        cnt1_nxt = cnt1_r + 1'b1;
      end
      if (cnt2_r + 1'b1 >= vs2sz_r) begin
        cnt2_nxt = '0;
        vs2_nxt  = 1'b1;
      end else begin
        cnt2_nxt = cnt2_r + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      cnt1_r  <= '0;
      cnt2_r  <= '0;
      vs1_r   <= 1'b0;
      vs2_r   <= 1'b0;
      len2_r  <= '0;
      lval_r  <= 1'b0;
      use_r   <= USE_NONE;
      vs2sz_r <= '0;
    end else begin
      cnt1_r  <= cnt1_nxt;
      cnt2_r  <= cnt2_nxt;
      vs1_r   <= vs1_nxt;
      vs2_r   <= vs2_nxt;
      len2_r  <= len2_nxt;
      lval_r  <= lval_nxt;
      use_r   <= use_nxt;
      vs2sz_r <= vs2sz_nxt;
    end
  end

  assign len2_o       = len2_r;
  assign len2_valid_o = lval_r;
  assign len2_use_o   = use_r;
  assign vsize2_o     = vs2sz_r;
  assign line1_o      = cnt1_r;
  assign line2_o      = cnt2_r;
  assign vsync1_o     = vs1_r;
  assign vsync2_o     = vs2_r;

endmodule // chb_line_length_and_test_vsize

// file: tb/chb_props.sv
// Purpose: Port assertions
// Assumes: One clock
// Notes: Bound below
module chb_props #(parameter int LEN_W = 12) (
  input wire logic             sys_clk_i, rstn_i, avs_read_i, avs_waitrequest_o,
  input wire logic             line_en_i, len2_valid_o, vsync1_o,
  input wire logic [31:0]      avs_readdata_o,
  input wire logic [1:0]       avs_response_o, len2_use_o,
  input wire logic [LEN_W-1:0] len2_o, line1_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  property p_ack; avs_waitrequest_o |=> !avs_waitrequest_o; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_req; $rose(avs_read_i) |-> avs_waitrequest_o; endproperty
  a_req: assert property (p_req) else $error("ack early");
  property p_hi; avs_readdata_o[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper bits set");
  property p_resp; avs_response_o inside {2'h0, 2'h2}; endproperty
  a_resp: assert property (p_resp) else $error("bad response");
  property p_one; !len2_valid_o |-> len2_o == '0 && len2_use_o == 2'h0; endproperty
  a_one: assert property (p_one) else $error("length used");
  property p_two; len2_use_o == 2'h3 |-> len2_valid_o; endproperty
  a_two: assert property (p_two) else $error("two streams");
  property p_step; line_en_i |=> line1_o == '0 || line1_o == $past(line1_o) + 1'b1; endproperty
  a_step: assert property (p_step) else $error("bad step");
  property p_hold; !line_en_i |=> $stable(line1_o); endproperty
  a_hold: assert property (p_hold) else $error("line moved");
  property p_vs; vsync1_o |-> line1_o == '0; endproperty
  a_vs: assert property (p_vs) else $error("vsync off wrap");
endmodule // chb_props
bind chb_line_length_and_test_vsize chb_props #(.LEN_W(LEN_W)) chb_props_inst (.sys_clk_i,
  .rstn_i, .avs_read_i, .avs_waitrequest_o, .line_en_i, .len2_valid_o, .vsync1_o,
  .avs_readdata_o, .avs_response_o, .len2_use_o, .len2_o, .line1_o);

// file: tb/line_pacer.sv
// Purpose: Test line source
// Assumes: One clock
// Notes: Pulse every 4 cycles
module line_pacer (
  input  wire logic sys_clk_i,
  input  wire logic go_i,
  output logic      line_en_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] ph_r = 2'h0;
  initial line_en_o = 1'b0;
  always @(posedge sys_clk_i) begin
    ph_r <= go_i ? ph_r + 2'h1 : 2'h0;
    line_en_o <= go_i && ph_r == 2'h3;
  end
endmodule // line_pacer

// file: tb/tb_top.sv
// Purpose: Bench for second length and test sizes
// Assumes: Two-cycle bus access
// Notes: Pacer drives test lines
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import chb_cfg_pkg::*;
  logic        sys_clk_i = 0, rstn_i = 0, rd = 0, wr = 0, go = 0, vld, vs1, vs2, wt, len_w;
  logic [9:0]  adr = '0;
  logic [31:0] wd = '0, rdat, rq;
  logic [1:0]  rsp, use2, rr;
  logic [11:0] len2, vsz2, l1, l2;
  int          n_errors = 0, cmp_count = 0, cyc = 0, nl = 0, nv1 = 0, nv2 = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  chb_line_length_and_test_vsize chb_line_length_and_test_vsize_inst (.sys_clk_i, .rstn_i,
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(4'hF), .avs_readdata_o(rdat), .avs_waitrequest_o(wt),
    .avs_response_o(rsp), .line_en_i(len_w), .len2_o(len2), .len2_valid_o(vld),
    .len2_use_o(use2), .vsize2_o(vsz2), .line1_o(l1), .line2_o(l2), .vsync1_o(vs1),
    .vsync2_o(vs2));
  line_pacer line_pacer_inst (.sys_clk_i, .go_i(go), .line_en_o(len_w));
  always @(negedge sys_clk_i) begin
    cyc <= cyc + 1;
    nl <= nl + len_w;
    nv1 <= nv1 + vs1;
    nv2 <= nv2 + vs2;
    if (cyc == 20000) begin
      n_errors++;
      final_report();
    end
  end
  task automatic final_report();
    if (n_errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] ix, d);
    @(posedge sys_clk_i);
    adr <= {ix, 2'h0};
    rd <= !w;
    wr <= w;
    wd <= {24'h0, d};
    do @(posedge sys_clk_i); while (wt !== 1'b0);
    rq = rdat;
    rr = rsp;
    rd <= 0;
    wr <= 0;
  endtask
  task automatic rchk(input logic [7:0] ix, d, input logic [1:0] r);
    bus(0, ix, 8'h00);
    chk(rq, {24'h0, d}, "read data");
    chk(rr, r, "response");
  endtask
  task automatic t_regs();
    for (int i = 0; i < 6; i++) begin
      rchk(8'(OFS_LEN2_LO + i), 8'h00, 2'h0);
      bus(1, 8'(OFS_LEN2_LO + i), 8'(8'hA0 + i));
      rchk(8'(OFS_LEN2_LO + i), 8'(8'hA0 + i), 2'h0);
    end
    rchk(8'h30, 8'h00, 2'h2);
  endtask
  task automatic t_modes();
    logic [7:0] md [5] = '{8'h00, 8'h14, 8'h04, 8'h0E, 8'h06};
    logic [1:0] us [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h2};
    bus(1, OFS_LEN2_LO, 8'h5C);
    for (int i = 0; i < 5; i++) begin
      bus(1, OFS_MODE, md[i]);
      repeat (2) @(negedge sys_clk_i);
      chk(use2, us[i], "use");
      chk(len2, md[i][2] ? 12'h15C : 12'h0, "length");
      chk(vsz2, i == 3 ? 12'h5A4 : 12'h3A2, "vsize");
    end
  endtask
  task automatic t_frame(input logic [7:0] md, v2);
    int bl, b1, b2, s2;
    s2 = md == 8'h0E ? v2 : 3;
    @(posedge sys_clk_i);
    rstn_i <= 0;
    repeat (2) @(posedge sys_clk_i);
    rstn_i <= 1;
    bus(1, OFS_VS1_LO, 8'h03);
    bus(1, OFS_VS2_LO, v2);
    bus(1, OFS_MODE, md);
    bl = nl;
    b1 = nv1;
    b2 = nv2;
    go <= 1;
    while (nl - bl < 7) @(posedge sys_clk_i);
    go <= 0;
    repeat (8) @(posedge sys_clk_i);
    chk(nv1 - b1, 7 / 3, "frames one");
    chk(l1, 7 % 3, "line one");
    chk(nv2 - b2, 7 / s2, "frames two");
    chk(l2, 7 % s2, "line two");
  endtask
  initial begin
    repeat (16) @(posedge sys_clk_i);
    rstn_i <= 1;
    t_regs();
    t_modes();
    t_frame(8'h00, 8'h02);
    t_frame(8'h0E, 8'h02);
    final_report();
  end
endmodule // tb_top
